// File: logic/lpw_pkg.sv
// Package for the low-power wake-up controller: modes, vectors, recovery counts and carriers.
// Assumes a single 250 MHz crystal-derived clock feeds every user of this package.
package lpw_pkg;

  typedef enum logic [1:0] {
    LPW_RUN = 2'b00,
    LPW_WAIT = 2'b01,
    LPW_STOP = 2'b11,
    LPW_RECOVER = 2'b10
  } lpw_mode_e;

  typedef logic [15:0] lpw_vec_t;

  localparam lpw_vec_t LPW_VEC_RESET = 16'hFFFE;
  localparam lpw_vec_t LPW_VEC_BREAK = 16'hFFFC;
  localparam lpw_vec_t LPW_VEC_EXT_PIN = 16'hFFFA;
  localparam lpw_vec_t LPW_VEC_PLL = 16'hFFF8;
  localparam lpw_vec_t LPW_VEC_T1_CH0 = 16'hFFF6;
  localparam lpw_vec_t LPW_VEC_T1_CH1 = 16'hFFF4;
  localparam lpw_vec_t LPW_VEC_T1_OVF = 16'hFFF2;
  localparam lpw_vec_t LPW_VEC_T2_CH0 = 16'hFFF0;
  localparam lpw_vec_t LPW_VEC_T2_OVF = 16'hFFEC;
  localparam lpw_vec_t LPW_VEC_SS_RX = 16'hFFEA;
  localparam lpw_vec_t LPW_VEC_SS_TX = 16'hFFE8;
  localparam lpw_vec_t LPW_VEC_AS_ERR = 16'hFFE6;
  localparam lpw_vec_t LPW_VEC_AS_RX = 16'hFFE4;
  localparam lpw_vec_t LPW_VEC_AS_TX = 16'hFFE2;
  localparam lpw_vec_t LPW_VEC_ADC_KEY = 16'hFFDE;
  localparam lpw_vec_t LPW_VEC_TIMEBASE = 16'hFFDC;

  localparam int LPW_REC_W = 12;
  localparam int LPW_REC_FULL_CYC = 4096;
  localparam int LPW_REC_SHORT_CYC = 32;
  localparam logic [LPW_REC_W-1:0] LPW_REC_FULL_LOAD = 12'hFFF;
  localparam logic [LPW_REC_W-1:0] LPW_REC_SHORT_LOAD = 12'h01F;
  localparam logic [LPW_REC_W-1:0] LPW_REC_ZERO = 12'h000;

  localparam int LPW_NUM_IRQ = 15;

  // Peripheral interrupt requests, each already gated by its own enable
  typedef struct packed {
    logic pll;
    logic t1_ovf;
    logic t1_ch1;
    logic t1_ch0;
    logic t2_ovf;
    logic t2_ch0;
    logic ss_tx;
    logic ss_rx;
    logic as_tx;
    logic as_rx;
    logic as_err;
    logic adc;
  } lpw_periph_irq_s;

  // Clock and run enables towards the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic osc_en;
    logic async_serial_run;
    logic sync_serial_run;
    logic timer_run;
    logic timebase_run;
    logic timebase_cpu_access;
  } lpw_gate_s;

endpackage

// File: logic/lpw_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the destination clock is clk; only the second stage may be read.
`timescale 1ns/1ps
module lpw_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: logic/lpw_vec_sel.sv
// Fixed-priority wake vector selector.
// Assumes requests arrive already qualified for the current mode.
`timescale 1ns/1ps
module lpw_vec_sel
  import lpw_pkg::*;
(
  input wire logic any_reset,
  input wire logic [lpw_pkg::LPW_NUM_IRQ-1:0] irq_req,
  output lpw_pkg::lpw_vec_t vector
);
  import lpw_pkg::*;
  // Index 0 is highest priority, ordered as the vector table
  localparam lpw_vec_t VEC_TAB [LPW_NUM_IRQ] = '{
    LPW_VEC_BREAK, LPW_VEC_EXT_PIN, LPW_VEC_PLL, LPW_VEC_T1_CH0, LPW_VEC_T1_CH1,
    LPW_VEC_T1_OVF, LPW_VEC_T2_CH0, LPW_VEC_T2_OVF, LPW_VEC_SS_RX, LPW_VEC_SS_TX,
    LPW_VEC_AS_ERR, LPW_VEC_AS_RX, LPW_VEC_AS_TX, LPW_VEC_ADC_KEY, LPW_VEC_TIMEBASE
  };

  always_comb
  begin
    vector = LPW_VEC_TIMEBASE;
    for (int i = LPW_NUM_IRQ - 1; i >= 0; i--)
    begin
      if (irq_req[i])
      begin
        vector = VEC_TAB[i];
      end
    end
    if (any_reset)
    begin
      vector = LPW_VEC_RESET;
    end
  end
endmodule

// File: logic/lpw_ctrl.sv
// Low-power wake-up controller: wait and stop mode tracking, wake qualification,
// vector selection, stop recovery counting and clock/peripheral gating.
// Assumes the CPU pulses wait_req/stop_req for one cycle on the entry instruction;
// pins pass through lpw_sync; peripheral requests come from logic on clk.
// Behaviour
// - External pin wakes either mode when unmasked
// - Keypad wakes either mode when unmasked
// - Enabled supply monitor reset ends either mode
// - Serial and timer irqs end wait mode
// - Async serial halts in stop, then resumes
// - Sync serial resumes on irq, resets on reset
// - Timers freeze in stop, resume on interrupt
// - Timebase runs in wait, no CPU access
// - Timebase runs in stop with oscillator, wakes
// - Timebase idle in stop without oscillator
// - Pin, watchdog, supply resets vector to reset
// - Pin falling edge wakes, vectors to FFFA
// - Break interrupt wakes either mode, FFFC
// - PLL interrupt ends wait, FFF8
// - First timer irqs vector FFF2, FFF4, FFF6
// - Second timer irqs vector FFEC, FFF0
// - Sync serial irqs vector FFE8, FFEA
// - Async serial irqs vector FFE2, FFE4, FFE6
// - Converter and keypad share vector FFDE
// - Only listed sources end stop mode
// - Full stop recovery holds clocks 4096 cycles
// - Short recovery select gives 32 cycles
// - Wait gates CPU clock, bus runs
// - Stop gates CPU, bus unless oscillator runs
// - Entry clears mask; reset wake sets it
`timescale 1ns/1ps
module lpw_ctrl
  import lpw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wait_req,
  input wire logic stop_req,
  input wire logic ext_pin_n,
  input wire logic [7:0] keypad_pins_n,
  input wire logic ext_pin_irq_mask,
  input wire logic keypad_irq_mask,
  input wire logic reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic supply_monitor_en,
  input wire logic supply_monitor_reset_en,
  input wire logic supply_low,
  input wire logic break_irq,
  input wire logic timebase_irq,
  input wire logic osc_run_in_stop,
  input wire logic short_recovery_select,
  input wire lpw_pkg::lpw_periph_irq_s periph_irq,
  output lpw_pkg::lpw_mode_e mode,
  output logic wake,
  output lpw_pkg::lpw_vec_t wake_vector,
  output logic wake_by_reset,
  output logic cpu_irq_mask_clr,
  output logic cpu_irq_mask_set,
  output logic sync_serial_abort,
  output lpw_pkg::lpw_gate_s gates
);
  import lpw_pkg::*;

  logic ext_pin_s;
  logic [7:0] keypad_s;
  logic reset_pin_s;
  logic ext_pin_prev_q;
  logic [7:0] keypad_prev_q;
  logic ext_fall;
  logic key_fall;
  logic in_wait;
  logic in_stop;
  logic tb_active;
  logic rst_src;
  logic [LPW_NUM_IRQ-1:0] irq_req;
  logic wake_any;
  lpw_vec_t vec_sel;
  lpw_mode_e mode_q;
  lpw_mode_e mode_d;
  logic [LPW_REC_W-1:0] rec_cnt_q;
  logic rec_reset_q;
  logic watchdog_src;
  logic supply_rst_src;
  logic nxt_run;
  logic nxt_wait;
  logic nxt_stop;

  // Pins reset to their idle-high level, so rstn brings no false edge or reset
  lpw_sync #(.W(10), .RST_VAL('1)) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({ext_pin_n, keypad_pins_n, reset_pin_n}),
    .sync_out({ext_pin_s, keypad_s, reset_pin_s})
  );

  // Edge history starts high so an idle-high pin gives no false edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_pin_prev_q <= 1'b1;
      keypad_prev_q <= 8'hFF;
    end
    else
    begin
      ext_pin_prev_q <= ext_pin_s;
      keypad_prev_q <= keypad_s;
    end
  end

  assign ext_fall = ext_pin_prev_q & ~ext_pin_s & ~ext_pin_irq_mask;
  assign key_fall = (|(keypad_prev_q & ~keypad_s)) & ~keypad_irq_mask;

  assign in_wait = (mode_q == LPW_WAIT);
  assign in_stop = (mode_q == LPW_STOP);
  assign tb_active = ~in_stop | osc_run_in_stop;

  // Reset sources; the supply monitor only counts when both enables are set
  assign supply_rst_src = supply_monitor_en & supply_monitor_reset_en & supply_low;
  // The watchdog has no clock in stop, so a timeout level there is stale
  assign watchdog_src = watchdog_timeout & ~in_stop;
  assign rst_src = ~reset_pin_s | watchdog_src | supply_rst_src;

  // Stop mode admits only pin edges, break and a running timebase
  always_comb
  begin
    irq_req = '0;
    irq_req[0] = break_irq;
    irq_req[1] = ext_fall;
    irq_req[13] = key_fall;
    irq_req[14] = timebase_irq & tb_active;
    if (!in_stop)
    begin
      irq_req[2] = periph_irq.pll;
      irq_req[3] = periph_irq.t1_ch0;
      irq_req[4] = periph_irq.t1_ch1;
      irq_req[5] = periph_irq.t1_ovf;
      irq_req[6] = periph_irq.t2_ch0;
      irq_req[7] = periph_irq.t2_ovf;
      irq_req[8] = periph_irq.ss_rx;
      irq_req[9] = periph_irq.ss_tx;
      irq_req[10] = periph_irq.as_err;
      irq_req[11] = periph_irq.as_rx;
      irq_req[12] = periph_irq.as_tx | periph_irq.adc;
    end
  end

  // ADC shares its vector with the keypad, so fold it in here
  lpw_vec_sel u_vec_sel (
    .any_reset(rst_src),
    .irq_req({irq_req[14], irq_req[13] | (irq_req[12] & periph_irq.adc & ~in_stop),
              irq_req[12] & periph_irq.as_tx, irq_req[11:0]}),
    .vector(vec_sel)
  );

  // Recovery takes no new source; the first waking source owns the vector
  assign wake_any = (in_wait | in_stop) & (rst_src | (|irq_req));

  assign nxt_run = (mode_d == LPW_RUN);
  assign nxt_wait = (mode_d == LPW_WAIT);
  assign nxt_stop = (mode_d == LPW_STOP);

  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      LPW_RUN:
      begin
        // Stop wins when both entry pulses arrive together
        if (stop_req)
        begin
          mode_d = LPW_STOP;
        end
        else if (wait_req)
        begin
          mode_d = LPW_WAIT;
        end
      end
      LPW_WAIT:
      begin
        if (wake_any)
        begin
          mode_d = LPW_RUN;
        end
      end
      LPW_STOP:
      begin
        if (wake_any)
        begin
          mode_d = LPW_RECOVER;
        end
      end
      LPW_RECOVER:
      begin
        // The count runs out even if the waking source has already gone
        if (rec_cnt_q == LPW_REC_ZERO)
        begin
          mode_d = LPW_RUN;
        end
      end
      default:
      begin
        mode_d = LPW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q <= LPW_RUN;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // Load value is cycles minus one; the exit cycle completes the count
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rec_cnt_q <= LPW_REC_ZERO;
    end
    else if (in_stop && wake_any)
    begin
      rec_cnt_q <= short_recovery_select ? LPW_REC_SHORT_LOAD : LPW_REC_FULL_LOAD;
    end
    else if (rec_cnt_q != LPW_REC_ZERO)
    begin
      rec_cnt_q <= rec_cnt_q - 1'b1;
    end
  end

  // Wake is announced once clocks are back: at once from wait, after recovery from stop
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wake <= 1'b0;
      wake_vector <= LPW_VEC_RESET;
      wake_by_reset <= 1'b0;
      rec_reset_q <= 1'b0;
      cpu_irq_mask_clr <= 1'b0;
      cpu_irq_mask_set <= 1'b0;
      sync_serial_abort <= 1'b0;
      mode <= LPW_RUN;
    end
    else
    begin
      mode <= mode_d;
      wake <= 1'b0;
      cpu_irq_mask_clr <= (mode_q == LPW_RUN) & (wait_req | stop_req);
      cpu_irq_mask_set <= 1'b0;
      sync_serial_abort <= 1'b0;
      if (wake_any)
      begin
        wake_vector <= vec_sel;
        rec_reset_q <= rst_src;
        sync_serial_abort <= in_stop & rst_src;
      end
      if (in_wait && wake_any)
      begin
        wake <= 1'b1;
        wake_by_reset <= rst_src;
        cpu_irq_mask_set <= rst_src;
      end
      else if (mode_q == LPW_RECOVER && rec_cnt_q == LPW_REC_ZERO)
      begin
        wake <= 1'b1;
        wake_by_reset <= rec_reset_q;
        cpu_irq_mask_set <= rec_reset_q;
      end
    end
  end

  // Clock and run enables follow the next mode so they change with it
  // Recovery is neither run nor wait, so CPU, bus, serial and timer enables stay off until the count ends; oscillator and timebase stay on
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gates <= '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1, osc_en: 1'b1, async_serial_run: 1'b1,
                 sync_serial_run: 1'b1, timer_run: 1'b1, timebase_run: 1'b1,
                 timebase_cpu_access: 1'b1};
    end
    else
    begin
      gates.cpu_clk_en <= nxt_run;
      gates.bus_clk_en <= nxt_run | nxt_wait | (nxt_stop & osc_run_in_stop);
      gates.osc_en <= ~nxt_stop | osc_run_in_stop;
      gates.async_serial_run <= nxt_run | nxt_wait;
      gates.sync_serial_run <= nxt_run | nxt_wait;
      gates.timer_run <= nxt_run | nxt_wait;
      gates.timebase_run <= ~nxt_stop | osc_run_in_stop;
      gates.timebase_cpu_access <= nxt_run;
    end
  end
endmodule

// File: bench/lpw_props.sv
// Port checker for the wake-up controller, bound onto every lpw_ctrl.
// Assumes one clock domain, clk with asynchronous active-low rstn.
`timescale 1ns/1ps
module lpw_props
  import lpw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wait_req,
  input wire logic stop_req,
  input wire logic osc_run_in_stop,
  input wire logic short_recovery_select,
  input wire lpw_pkg::lpw_periph_irq_s periph_irq,
  input wire lpw_pkg::lpw_mode_e mode,
  input wire logic wake,
  input wire lpw_pkg::lpw_vec_t wake_vector,
  input wire logic wake_by_reset,
  input wire logic cpu_irq_mask_clr,
  input wire logic cpu_irq_mask_set,
  input wire lpw_pkg::lpw_gate_s gates
);
  import lpw_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [12:0] rec_cnt_q;
  // Counts recovery cycles so the 4096-cycle hold is checked without long repetitions
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rec_cnt_q <= 13'h0000;
    else if (mode == LPW_RECOVER)
      rec_cnt_q <= rec_cnt_q + 13'h0001;
    else
      rec_cnt_q <= 13'h0000;
  end
  sequence s_enter_wait;
    mode == LPW_RUN && wait_req && !stop_req;
  endsequence
  sequence s_stop_taken;
    mode == LPW_STOP ##1 mode == LPW_RECOVER;
  endsequence
  property p_wait_entry;
    s_enter_wait |=> mode == LPW_WAIT && cpu_irq_mask_clr;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");
  property p_wait_gates;
    mode == LPW_WAIT |-> !gates.cpu_clk_en && gates.bus_clk_en && gates.timer_run && !gates.timebase_cpu_access;
  endproperty
  a_wait_gates: assert property (p_wait_gates) else $error("wait gating wrong");
  property p_stop_gates;
    mode == LPW_STOP |-> !gates.cpu_clk_en && !gates.timer_run && !gates.async_serial_run
      && !gates.sync_serial_run && gates.bus_clk_en == osc_run_in_stop && gates.timebase_run == osc_run_in_stop;
  endproperty
  a_stop_gates: assert property (p_stop_gates) else $error("stop gating wrong");
  property p_run_gates;
    mode == LPW_RUN |-> gates == 8'hFF;
  endproperty
  a_run_gates: assert property (p_run_gates) else $error("run gating wrong");
  property p_wait_wake;
    mode == LPW_WAIT && periph_irq != 12'h000 |=> wake && mode == LPW_RUN;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("wait not ended");
  property p_stop_short;
    s_stop_taken ##0 short_recovery_select |-> ##31 (mode == LPW_RECOVER && !wake) ##1 (wake && mode == LPW_RUN);
  endproperty
  a_stop_short: assert property (p_stop_short) else $error("short recovery wrong");
  property p_rec_len;
    wake && rec_cnt_q != 13'h0000 |-> rec_cnt_q == (short_recovery_select ? 13'h0020 : 13'h1000);
  endproperty
  a_rec_len: assert property (p_rec_len) else $error("recovery length wrong");
  property p_reset_vec;
    wake && wake_by_reset |-> wake_vector == 16'hFFFE && cpu_irq_mask_set;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset wake wrong");
  property p_irq_mask;
    wake && !wake_by_reset |-> !cpu_irq_mask_set;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("mask set on irq wake");
  property p_wake_pulse;
    $rose(wake) |=> $fell(wake);
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");
endmodule
bind lpw_ctrl lpw_props i_props (.clk(clk), .rstn(rstn), .wait_req(wait_req), .stop_req(stop_req),
  .osc_run_in_stop(osc_run_in_stop), .short_recovery_select(short_recovery_select), .periph_irq(periph_irq),
  .mode(mode), .wake(wake), .wake_vector(wake_vector), .wake_by_reset(wake_by_reset),
  .cpu_irq_mask_clr(cpu_irq_mask_clr), .cpu_irq_mask_set(cpu_irq_mask_set), .gates(gates));

// File: bench/lpw_cpu_model.sv
// CPU core stand-in: single-cycle wait/stop entry pulses and the external interrupt pin.
// Assumes callers act at a falling clock edge, away from the controller's sampling edge.
`timescale 1ns/1ps
module lpw_cpu_model
(
  input wire logic clk,
  output logic wait_req,
  output logic stop_req,
  output logic ext_pin_n
);
  initial
  begin
    wait_req = 1'b0;
    stop_req = 1'b0;
    ext_pin_n = 1'b1;
  end
  // Issued only while running, as the entry instruction would be
  task automatic enter(input logic stp);
    @(negedge clk);
    wait_req = !stp;
    stop_req = stp;
    @(negedge clk);
    wait_req = 1'b0;
    stop_req = 1'b0;
  endtask
  // Pin idles high; a wake is a high-to-low transition
  task automatic set_pin(input logic lvl);
    ext_pin_n = lvl;
  endtask
endmodule

// File: bench/low_power_wakeup_control_bench.sv
// Self-checking bench: enters wait and stop, fires each wake source, checks vectors and delays.
// Assumes the lpw_props checker is bound onto the controller.
`timescale 1ns/1ps
module low_power_wakeup_control_bench;
  import lpw_pkg::*;
  logic clk, rstn, ext_irq_mask, key_mask, reset_pin_n, watchdog_timeout, sm_reset_en, supply_low;
  logic break_irq, timebase_irq, osc_run_in_stop, short_sel, wait_req, stop_req, ext_pin_n;
  logic wake, wake_by_reset, mask_clr, mask_set, abort, abort_seen, sm_en;
  logic [7:0] keypad_pins_n;
  lpw_periph_irq_s periph_irq;
  lpw_mode_e mode;
  lpw_vec_t wake_vector;
  lpw_gate_s gates;
  int failures, checks_done;
  localparam lpw_vec_t PV [12] = '{16'hFFDE, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFEA, 16'hFFE8,
    16'hFFF0, 16'hFFEC, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF8};
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  lpw_cpu_model i_cpu (.clk(clk), .wait_req(wait_req), .stop_req(stop_req), .ext_pin_n(ext_pin_n));
  lpw_ctrl i_dut (.clk(clk), .rstn(rstn), .wait_req(wait_req), .stop_req(stop_req), .ext_pin_n(ext_pin_n),
    .keypad_pins_n(keypad_pins_n), .ext_pin_irq_mask(ext_irq_mask), .keypad_irq_mask(key_mask),
    .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout), .supply_monitor_en(sm_en),
    .supply_monitor_reset_en(sm_reset_en), .supply_low(supply_low), .break_irq(break_irq),
    .timebase_irq(timebase_irq), .osc_run_in_stop(osc_run_in_stop), .short_recovery_select(short_sel),
    .periph_irq(periph_irq), .mode(mode), .wake(wake), .wake_vector(wake_vector),
    .wake_by_reset(wake_by_reset), .cpu_irq_mask_clr(mask_clr), .cpu_irq_mask_set(mask_set),
    .sync_serial_abort(abort), .gates(gates));
  always @(posedge clk)
    if (abort === 1'b1)
      abort_seen <= 1'b1;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Sources 0-11 are peripheral bits; the rest are break, timebase, pins, resets and combined cases
  task automatic src(input int n, input logic on);
    @(negedge clk);
    if (n < 12)
      periph_irq[n] = on;
    else
      case (n)
        12: break_irq = on;
        13: timebase_irq = on;
        14: keypad_pins_n[3] = !on;
        15: watchdog_timeout = on;
        16: supply_low = on;
        17: reset_pin_n = !on;
        18: i_cpu.set_pin(!on);
        19: periph_irq = on ? 12'hFFF : 12'h000;
        default:
        begin
          watchdog_timeout = on;
          break_irq = on;
        end
      endcase
  endtask
  task automatic await(input int n, input logic stp, input lpw_vec_t exp);
    abort_seen = 1'b0;
    src(n, 1'b1);
    repeat (5000)
    begin
      @(negedge clk);
      if (wake === 1'b1)
        break;
    end
    check("wake", wake, 1'b1);
    check("vector", wake_vector, exp);
    check("by_reset", wake_by_reset, exp == 16'hFFFE);
    check("abort", abort_seen, stp && exp == 16'hFFFE);
    check("run", mode, LPW_RUN);
    src(n, 1'b0);
  endtask
  task automatic trial(input logic stp, input int n, input lpw_vec_t exp);
    i_cpu.enter(stp);
    check("mode", mode, stp ? LPW_STOP : LPW_WAIT);
    check("mask_clr", mask_clr, 1'b1);
    await(n, stp, exp);
  endtask
  // A source that must not end stop, then a break to leave it
  task automatic refuse(input int n);
    i_cpu.enter(1'b1);
    src(n, 1'b1);
    repeat (20) @(negedge clk);
    check("held", mode, LPW_STOP);
    src(n, 1'b0);
    await(12, 1'b1, 16'hFFFC);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #240000;
    failures++;
    wrap_up();
  end
  initial
  begin
    {rstn, ext_irq_mask, key_mask, watchdog_timeout, supply_low, break_irq, timebase_irq} = 7'h00;
    {osc_run_in_stop, short_sel, reset_pin_n, sm_reset_en, abort_seen} = 5'h0C;
    keypad_pins_n = 8'hFF;
    sm_en = 1'b1;
    periph_irq = 12'h000;
    failures = 0;
    checks_done = 0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    check("rst_mode", mode, LPW_RUN);
    check("rst_gates", gates, 8'hFF);
    for (int i = 0; i < 12; i++)
      trial(1'b0, i, PV[i]);
    trial(1'b0, 12, 16'hFFFC);
    trial(1'b0, 13, 16'hFFDC);
    trial(1'b0, 18, 16'hFFFA);
    trial(1'b0, 14, 16'hFFDE);
    trial(1'b0, 15, 16'hFFFE);
    trial(1'b0, 19, 16'hFFF8);
    trial(1'b0, 20, 16'hFFFE);
    $display("test wait done");
    refuse(11);
    refuse(13);
    refuse(15);
    ext_irq_mask = 1'b1;
    refuse(18);
    key_mask = 1'b1;
    refuse(14);
    sm_reset_en = 1'b0;
    refuse(16);
    {sm_en, sm_reset_en} = 2'h1;
    refuse(16);
    {ext_irq_mask, key_mask, sm_reset_en, sm_en} = 4'h3;
    $display("test refuse done");
    trial(1'b1, 18, 16'hFFFA);
    trial(1'b1, 17, 16'hFFFE);
    short_sel = 1'b1;
    trial(1'b1, 14, 16'hFFDE);
    trial(1'b1, 16, 16'hFFFE);
    trial(1'b1, 12, 16'hFFFC);
    osc_run_in_stop = 1'b1;
    trial(1'b1, 13, 16'hFFDC);
    $display("test stop done");
    wrap_up();
  end
endmodule
